// file: verilog/charger_protect_pkg.sv
// shared constants and types for the charger protection option registers
package charger_protect_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] OFFSET_SYS_PROTECT_HI = 8'h3d;
  localparam logic [7:0] OFFSET_DISCHARGE_LO = 8'h3c;
  localparam logic [7:0] RESET_SYS_PROTECT_HI = 8'h00;
  localparam logic [7:0] RESET_DISCHARGE_LO = 8'h48;

  // high byte field positions
  localparam int TRIP_LEVEL_LSB = 5;
  localparam int DITHER_LSB = 3;
  localparam int RETRY_DISABLE_BIT = 2;
  localparam int SAG_ENABLE_BIT = 1;
  localparam int SAG_FLAG_BIT = 0;
  // low byte field positions
  localparam int FILTER_TIME_LSB = 6;
  localparam int LIMIT2_PCT_LSB = 3;
  localparam int LIMIT2_ALERT_BIT = 2;

  // field codes
  localparam logic [2:0] TRIP_LEVEL_2V4 = 3'h0;
  localparam logic [1:0] DITHER_OFF = 2'h0;
  localparam logic [1:0] DITHER_2PCT = 2'h1;
  localparam logic [1:0] DITHER_4PCT = 2'h2;
  localparam logic [1:0] FILTER_100US = 2'h0;
  localparam logic [1:0] FILTER_1600US = 2'h1;
  localparam logic [1:0] FILTER_6MS = 2'h2;
  localparam logic [1:0] FILTER_12MS = 2'h3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint CLK_HZ = 100000000;
  localparam int RETRY_LIMIT = 7;
  localparam longint RETRY_WINDOW_S = 90;
  localparam longint HICCUP_OFF_MS = 10;
  localparam longint FILTER_100US_US = 100;
  localparam longint FILTER_1600US_US = 1600;
  localparam longint FILTER_6MS_US = 6000;
  localparam longint FILTER_12MS_US = 12000;
  localparam longint RETRY_WINDOW_CYCLES = RETRY_WINDOW_S * CLK_HZ;
  localparam longint HICCUP_OFF_CYCLES = HICCUP_OFF_MS * CLK_HZ / 1000;
  localparam longint FILTER_100US_CYCLES = FILTER_100US_US * CLK_HZ / 1000000;
  localparam longint FILTER_1600US_CYCLES = FILTER_1600US_US * CLK_HZ / 1000000;
  localparam longint FILTER_6MS_CYCLES = FILTER_6MS_US * CLK_HZ / 1000000;
  localparam longint FILTER_12MS_CYCLES = FILTER_12MS_US * CLK_HZ / 1000000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic sys_rail_low;
    logic input_sag;
    logic discharge_over_limit2;
  } sense_type;

  typedef enum logic [1:0] {RUN, HOLD_OFF, LATCHED} hiccup_state_type;

endpackage

// file: verilog/charger_protect_option_regs.sv
// protection option register pair with undervoltage hiccup and deglitch logic
`timescale 1ns/1ps
`default_nettype none
module charger_protect_option_regs #(
  parameter longint WINDOW_CYCLES = charger_protect_pkg::RETRY_WINDOW_CYCLES,
  parameter longint OFF_CYCLES = charger_protect_pkg::HICCUP_OFF_CYCLES,
  parameter longint F0_CYCLES = charger_protect_pkg::FILTER_100US_CYCLES,
  parameter longint F1_CYCLES = charger_protect_pkg::FILTER_1600US_CYCLES,
  parameter longint F2_CYCLES = charger_protect_pkg::FILTER_6MS_CYCLES,
  parameter longint F3_CYCLES = charger_protect_pkg::FILTER_12MS_CYCLES
) (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  // register access
  input wire charger_protect_pkg::reg_req_type REG_REQ_IN,
  output logic [7:0] REG_RDATA_OUT,
  // analog comparator levels
  input wire charger_protect_pkg::sense_type SENSE_IN,
  // controls to the power stage
  output logic [2:0] SYS_RAIL_LOW_TRIP_LEVEL_OUT,
  output logic [1:0] DITHER_MODE_OUT,
  output logic CHARGER_ON_OUT,
  output logic PROCESSOR_HOT_ALERT_OUT,
  output logic DISCHARGE_LIMIT2_TRIP_OUT
);
  import charger_protect_pkg::*;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [2:0] sense_meta;
  logic [2:0] sense_sync;
  logic sag_prev;

  // comparators are asynchronous to the clock
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sense_meta <= 3'h0;
      sense_sync <= 3'h0;
      sag_prev <= 1'b0;
    end else begin
      sense_meta <= SENSE_IN;
      sense_sync <= sense_meta;
      sag_prev <= sense_sync[1];
    end
  end

  wire uv_low = sense_sync[2];
  wire sag_rise = sense_sync[1] & ~sag_prev;
  wire over_limit2 = sense_sync[0];

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [2:0] trip_level;
  logic [1:0] dither;
  logic retry_disable;
  logic sag_enable;
  logic sag_flag;
  logic [1:0] filter_time;
  logic [2:0] limit2_pct;
  logic limit2_alert;

  wire hit_hi = REG_REQ_IN.addr == OFFSET_SYS_PROTECT_HI;
  wire hit_lo = REG_REQ_IN.addr == OFFSET_DISCHARGE_LO;
  wire wr_hi = REG_REQ_IN.wr & hit_hi;
  wire wr_lo = REG_REQ_IN.wr & hit_lo;
  wire rd_hi = REG_REQ_IN.rd & hit_hi;
  wire [7:0] rd_hi_val = {trip_level, dither, retry_disable, sag_enable, sag_flag};
  wire [7:0] rd_lo_val = {filter_time, limit2_pct, limit2_alert, 2'h0};
  wire [7:0] next_rdata = hit_hi ? rd_hi_val : (hit_lo ? rd_lo_val : 8'h00);
  // a new sag event on the read cycle survives the clear
  wire next_sag_flag = sag_rise | (sag_flag & ~rd_hi);

  // writable fields; flag and low two bits are read only
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      trip_level <= RESET_SYS_PROTECT_HI[7:5];
      dither <= RESET_SYS_PROTECT_HI[4:3];
      retry_disable <= RESET_SYS_PROTECT_HI[2];
      sag_enable <= RESET_SYS_PROTECT_HI[1];
      filter_time <= RESET_DISCHARGE_LO[7:6];
      limit2_pct <= RESET_DISCHARGE_LO[5:3];
      limit2_alert <= RESET_DISCHARGE_LO[2];
    end else begin
      if (wr_hi) begin
        trip_level <= REG_REQ_IN.wdata[TRIP_LEVEL_LSB +: 3];
        dither <= REG_REQ_IN.wdata[DITHER_LSB +: 2];
        retry_disable <= REG_REQ_IN.wdata[RETRY_DISABLE_BIT];
        sag_enable <= REG_REQ_IN.wdata[SAG_ENABLE_BIT];
      end
      if (wr_lo) begin
        filter_time <= REG_REQ_IN.wdata[FILTER_TIME_LSB +: 2];
        limit2_pct <= REG_REQ_IN.wdata[LIMIT2_PCT_LSB +: 3];
        limit2_alert <= REG_REQ_IN.wdata[LIMIT2_ALERT_BIT];
      end
    end
  end

  // read data and sticky sag flag
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sag_flag <= 1'b0;
      REG_RDATA_OUT <= 8'h00;
      PROCESSOR_HOT_ALERT_OUT <= 1'b0;
    end else begin
      sag_flag <= next_sag_flag;
      REG_RDATA_OUT <= next_rdata;
      PROCESSOR_HOT_ALERT_OUT <= sag_enable & next_sag_flag;
    end
  end

  // ****************************************************************
  // undervoltage hiccup
  // ****************************************************************
  hiccup_state_type state;
  hiccup_state_type next_state;
  logic [35:0] window_cnt;
  logic [35:0] off_cnt;
  logic [2:0] fail_cnt;

  wire window_done = window_cnt >= 36'(WINDOW_CYCLES);
  wire off_done = off_cnt >= 36'(OFF_CYCLES - 1);
  // restart attempt fails if the rail is still low when the off time ends
  wire restart_fail = (state == HOLD_OFF) & off_done & uv_low;
  wire restart_ok = (state == HOLD_OFF) & off_done & ~uv_low;
  wire give_up = restart_fail & (fail_cnt == 3'(RETRY_LIMIT - 1)) & ~window_done;

  always_comb begin
    next_state = state;
    case (state)
      RUN: begin
        if (uv_low) begin
          next_state = retry_disable ? LATCHED : HOLD_OFF;
        end
      end
      HOLD_OFF: begin
        if (retry_disable) begin
          next_state = LATCHED;
        end else if (give_up) begin
          next_state = LATCHED;
        end else if (off_done & ~uv_low) begin
          next_state = RUN;
        end
      end
      LATCHED: next_state = LATCHED; // only a reset on ARST_N_IN leaves
      default: next_state = RUN;
    endcase
  end

  // failure count and window clear on a good restart, retry disable or window expiry
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state <= RUN;
      fail_cnt <= 3'h0;
      window_cnt <= 36'h0;
      off_cnt <= 36'h0;
      CHARGER_ON_OUT <= 1'b1;
    end else begin
      state <= next_state;
      CHARGER_ON_OUT <= next_state == RUN;
      off_cnt <= (state == HOLD_OFF && !off_done) ? off_cnt + 36'h1 : 36'h0;
      if (restart_ok || retry_disable || (window_done && fail_cnt != 3'h0)) begin
        fail_cnt <= 3'h0;
        window_cnt <= 36'h0;
      end else if (restart_fail) begin
        fail_cnt <= fail_cnt + 3'h1;
        window_cnt <= (fail_cnt == 3'h0) ? 36'h0 : window_cnt;
      end else if (fail_cnt != 3'h0) begin
        window_cnt <= window_cnt + 36'h1;
      end
    end
  end

  // ****************************************************************
  // discharge limit 2 deglitch
  // ****************************************************************
  logic [23:0] filt_cnt;
  wire [23:0] filt_target = (filter_time == FILTER_100US) ? 24'(F0_CYCLES) :
                            (filter_time == FILTER_1600US) ? 24'(F1_CYCLES) :
                            (filter_time == FILTER_6MS) ? 24'(F2_CYCLES) : 24'(F3_CYCLES);
  wire filt_reached = filt_cnt >= filt_target;

  // any dropout of the comparator restarts the filter time
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      filt_cnt <= 24'h0;
      DISCHARGE_LIMIT2_TRIP_OUT <= 1'b0;
    end else begin
      filt_cnt <= !over_limit2 ? 24'h0 : (filt_reached ? filt_cnt : filt_cnt + 24'h1);
      DISCHARGE_LIMIT2_TRIP_OUT <= over_limit2 & filt_reached;
    end
  end

  // straight register copies to the power stage
  assign SYS_RAIL_LOW_TRIP_LEVEL_OUT = trip_level;
  assign DITHER_MODE_OUT = dither;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  AST_FLAG_HOLDS: assert property (sag_flag && !rd_hi |=> sag_flag)
    else $error("sag flag dropped without a read");
  AST_FLAG_READ_CLEARS: assert property (sag_flag && rd_hi && !sag_rise |=> !sag_flag)
    else $error("sag flag not cleared by read");
  AST_FLAG_SET_WINS: assert property (sag_rise |=> sag_flag)
    else $error("sag event lost");
  AST_ALERT_GATED: assert property (!sag_enable |=> !PROCESSOR_HOT_ALERT_OUT)
    else $error("hot alert while sag profile disabled");
  AST_LATCH_STAYS: assert property (state == LATCHED |=> state == LATCHED && !CHARGER_ON_OUT)
    else $error("left latched off");
  AST_NO_RETRY: assert property (state == RUN && uv_low && retry_disable |=> state == LATCHED)
    else $error("retry taken while disabled");
  AST_FAIL_LIMIT: assert property (fail_cnt == 3'(RETRY_LIMIT) |-> state == LATCHED)
    else $error("seventh failed restart did not latch off");
  AST_COUNT_CLEAR: assert property (restart_ok |=> fail_cnt == 3'h0 && window_cnt == 36'h0)
    else $error("counter not cleared after good restart");
  AST_FILTER_WAIT: assert property (DISCHARGE_LIMIT2_TRIP_OUT |-> $past(over_limit2) && $past(filt_reached))
    else $error("limit2 trip before deglitch time");
  AST_TRIP_WRITE: assert property (wr_hi |=> SYS_RAIL_LOW_TRIP_LEVEL_OUT == $past(REG_REQ_IN.wdata[7:5]))
    else $error("trip level not written");
  AST_DITHER_WRITE: assert property (wr_hi |=> DITHER_MODE_OUT == $past(REG_REQ_IN.wdata[4:3]))
    else $error("dither code not written");

endmodule
`default_nettype wire

// file: verif/prot_host_model.sv
// host side register access model for the protection option registers
`timescale 1ns/1ps
`default_nettype none
module prot_host_model (
  // clock
  input wire logic clk_in,
  // register port
  output var charger_protect_pkg::reg_req_type req_out,
  input wire logic [7:0] rdata_in
);
  import charger_protect_pkg::*;

  // start idle on an unmapped address
  initial begin
    req_out = '{addr: 8'hc2, wr: 1'b0, rd: 1'b0, wdata: 8'h5a};
  end

  // a released bus shows inverted values, so a stale request never looks held
  task automatic idle();
    req_out = '{addr: ~req_out.addr, wr: 1'b0, rd: 1'b0, wdata: ~req_out.wdata};
  endtask

  // one-cycle write strobe, driven between rising edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    req_out = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_in);
    idle();
  endtask

  // a read is the only acknowledge of a latched status bit
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    req_out = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~req_out.wdata};
    @(negedge clk_in);
    d = rdata_in;
    idle();
  endtask
endmodule
`default_nettype wire

// file: verif/charger_protect_option_regs_tb.sv
// self-checking bench for the protection option register pair
`timescale 1ns/1ps
`default_nettype none
module charger_protect_option_regs_tb;
  import charger_protect_pkg::*;
  // shortened deglitch counts keep the run small
  localparam int FT [4] = '{5, 10, 15, 20};
  logic clk;
  logic arst_n;
  reg_req_type req;
  sense_type sense;
  logic [7:0] rdata;
  logic [2:0] lvl;
  logic [1:0] dith;
  logic on;
  logic hot;
  logic trip2;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  // full-length retry window; every restart burst here ends long before it runs out
  charger_protect_option_regs #(.OFF_CYCLES(20), .F0_CYCLES(5),
    .F1_CYCLES(10), .F2_CYCLES(15), .F3_CYCLES(20)) charger_protect_option_regs_i (
    .SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .REG_REQ_IN(req), .REG_RDATA_OUT(rdata),
    .SENSE_IN(sense), .SYS_RAIL_LOW_TRIP_LEVEL_OUT(lvl), .DITHER_MODE_OUT(dith),
    .CHARGER_ON_OUT(on), .PROCESSOR_HOT_ALERT_OUT(hot), .DISCHARGE_LIMIT2_TRIP_OUT(trip2));
  prot_host_model prot_host_model_i (.clk_in(clk), .req_out(req), .rdata_in(rdata));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, well above the roughly nine hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    prot_host_model_i.rd(a, d);
    chk(d, exp);
  endtask

  task automatic waitn(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic do_reset();
    @(negedge clk);
    arst_n = 1'b0;
    waitn(12);
    arst_n = 1'b1;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    int n;
    logic [7:0] d;
    sense = '0;
    arst_n = 1'b0;
    do_reset();
    rchk(8'h3d, 8'h00);
    rchk(8'h3c, 8'h48);
    rchk(8'h55, 8'h00);
    chk(8'(on), 8'h01);
    $display("test reset done");
    // every trip level and dither code; the status bit ignores writes
    for (int i = 0; i < 8; i++) begin
      d = {i[2:0], 2'(i % 3), 3'b001};
      prot_host_model_i.wr(8'h3d, d);
      chk(8'(lvl), 8'(i));
      chk(8'(dith), 8'(i % 3));
      rchk(8'h3d, {d[7:1], 1'b0});
    end
    $display("test fields done");
    // each deglitch code, measured from the input edge
    for (int c = 0; c < 4; c++) begin
      prot_host_model_i.wr(8'h3c, {2'(c), 6'h3f});
      rchk(8'h3c, {2'(c), 6'h3c});
      sense.discharge_over_limit2 = 1'b1;
      n = 0;
      while (trip2 !== 1'b1 && n < 40) begin
        @(negedge clk);
        n++;
      end
      chk(8'(n >= FT[c] && n <= FT[c] + 6), 8'h01);
      sense.discharge_over_limit2 = 1'b0;
      waitn(6);
      chk(8'(trip2), 8'h00);
    end
    $display("test deglitch done");
    // sag flag sticks after the input drops; alert only when enabled
    for (int e = 0; e < 2; e++) begin
      prot_host_model_i.wr(8'h3d, {6'h0, 1'(e), 1'b0});
      sense.input_sag = 1'b1;
      waitn(6);
      sense.input_sag = 1'b0;
      waitn(6);
      chk(8'(hot), 8'(e));
      rchk(8'h3d, {6'h0, 1'(e), 1'b1});
      waitn(2);
      chk(8'(hot), 8'h00);
      rchk(8'h3d, {6'h0, 1'(e), 1'b0});
    end
    $display("test sag done");
    // two short episodes: the failure count must not carry over
    prot_host_model_i.wr(8'h3d, 8'h00);
    for (int k = 0; k < 2; k++) begin
      sense.sys_rail_low = 1'b1;
      waitn(10);
      chk(8'(on), 8'h00);
      waitn(80);
      sense.sys_rail_low = 1'b0;
      waitn(60);
      chk(8'(on), 8'h01);
    end
    // held low through seven restarts: stays off after the rail recovers
    sense.sys_rail_low = 1'b1;
    waitn(200);
    sense.sys_rail_low = 1'b0;
    waitn(100);
    chk(8'(on), 8'h00);
    do_reset();
    chk(8'(on), 8'h01);
    // retries disabled: the first trip latches off
    prot_host_model_i.wr(8'h3d, 8'h04);
    sense.sys_rail_low = 1'b1;
    waitn(10);
    sense.sys_rail_low = 1'b0;
    waitn(60);
    chk(8'(on), 8'h00);
    $display("test hiccup done");
    close_out();
  end
endmodule
`default_nettype wire
